// ===== hw/pei_pkg.sv
package pei_pkg;
	localparam int        CLK_PERIOD_NS   = 8;            // System clock period
	localparam int        MEM_BYTES       = 2048;         // Memory size in bytes
	localparam int        ADDR_W          = 11;           // Memory address width
	localparam int        PAGE_BITS       = 4;            // Low address bits inside one page
	localparam int        PAGE_BYTES      = 16;           // Bytes per page
	localparam logic [3:0] DEV_TYPE_CODE  = 4'h5;         // Device-type code, value arbitrary
	localparam logic [10:0] ADDR_WIPER    = 11'h7ff;      // Wiper / initial value location
	localparam logic [10:0] ADDR_VOL_SEL  = 11'h7fe;      // Volatile-only select location
	localparam logic [7:0] WIPER_RESET    = 8'h40;        // Wiper position at power-up
	localparam logic [7:0] INIT_WIPER_RST = 8'h40;        // Initial wiper value store default
	localparam int        NV_WRITE_US     = 5;            // Non-volatile write cycle time
	localparam int        NV_WRITE_CYC    = NV_WRITE_US * 1000 / CLK_PERIOD_NS;
	localparam int        POWERUP_CYC     = 16;           // Power-up sequence length
	localparam int        LINK_DIV        = 8;            // Quarter link clock period in clocks
endpackage : pei_pkg

// ===== hw/pei_link_if.sv
`timescale 1ns/1ps
// Two-wire link; both lines are open drain, resolved from the enables
interface pei_link_if;
	logic scl_o;     // Clock driven by master (low when enabled)
	logic scl_oe;    // Master pulls clock low
	logic sda_m_oe;  // Master pulls data low
	logic sda_s_oe;  // Slave pulls data low
	logic scl;       // Resolved clock level
	logic sda;       // Resolved data level
	assign scl = ~scl_oe;
	assign sda = ~(sda_m_oe | sda_s_oe);
	modport device (input scl, input sda, output sda_s_oe);
	modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_oe);
endinterface : pei_link_if

// ===== hw/pei_slave.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Bytes shift most-significant bit first
// [R2] Data changes in clock low; edges mark START/STOP
// [R3] START ignored during power-up and write cycle
// [R4] STOP after read or volatile write: standby
// [R5] STOP after non-volatile write starts write cycle
// [R6] Receiver pulls data low in ninth period
// [R7] Acknowledge identification, address, each write byte
// [R8] Master leaves last read byte unacknowledged
// [R9] Identification byte: code, address high, direction
// [R10] Eleven-bit address from identification and address
// [R11] Write cycle ignores link, data released
// [R12] Sixteen-byte pages commit in one cycle
// [R13] Later write bytes go to next address, wrapping within the page
// [R14] Master keeps each write within one page
// [R15] Write protect low: no data acknowledge, standby
// [R16] All-ones address loads wiper on LSB fall
// [R17] Read uses dummy write then repeated START
// [R18] Device transmits while master keeps acknowledging
// [R19] Read pointer loads address, increments per byte
// [R20] Data pin released after power-up
// [R21] Reading 7FF selects wiper or initial value
// [R22] Writing 7FF updates wiper, maybe initial value
// [R23] Wrong device code: no acknowledge, idle
module pei_slave #(
	parameter int NV_CYC = pei_pkg::NV_WRITE_CYC    // Write cycle length in clocks
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	pei_link_if.device      link,
	input  wire logic       write_protect_n,
	output logic [7:0]      wiper_position_register,
	output logic            nv_busy
);
	typedef enum logic [2:0] {
		PEI_IDLE = 3'b000, PEI_ID = 3'b001, PEI_ADDR = 3'b011, PEI_WDATA = 3'b010,
		PEI_RDATA = 3'b110, PEI_RACK = 3'b111, PEI_NVW = 3'b101, PEI_PWR = 3'b100
	} pei_state_t;

	logic [7:0]  mem [pei_pkg::MEM_BYTES];  // Non-volatile array
	logic [7:0]  page_buf [pei_pkg::PAGE_BYTES]; // Pending page bytes
	logic [pei_pkg::PAGE_BYTES-1:0] page_vld_reg; // Which page bytes pending
	logic [10:0] page_base_reg;              // Page being written
	logic [1:0]  scl_sync_reg, sda_sync_reg; // Synchronisers
	logic [1:0]  wp_sync_reg;                // Write-protect pin synchroniser
	logic        scl_d_reg, sda_d_reg;       // Previous synchronised levels
	pei_state_t  state_reg;                  // Transfer state
	logic [3:0]  bit_cnt_reg;                // Bit in byte, 8 = ack slot, f = after START
	logic [7:0]  shift_reg;                  // Receive / transmit shift register
	logic [10:0] ptr_reg;                    // Address pointer
	logic        volatile_only_select;       // Access control bit
	logic [7:0]  initial_wiper_value_store;  // Non-volatile initial wiper value
	logic        nv_pending_reg;             // Write holds non-volatile bytes
	logic        sda_oe_reg;                 // Pull data low
	logic [31:0] timer_reg;                  // Power-up / write cycle timer
	logic        scl_rise, scl_fall, start_c, stop_c;
	logic        scl_s, sda_s;
	logic [7:0]  rd_byte;

	assign scl_s     = scl_sync_reg[1];
	assign sda_s     = sda_sync_reg[1];
	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_c   = scl_s & scl_d_reg & sda_d_reg & ~sda_s;   // [R2]
	assign stop_c    = scl_s & scl_d_reg & ~sda_d_reg & sda_s;   // [R2]
	assign link.sda_s_oe = sda_oe_reg;
	assign nv_busy   = (state_reg == PEI_NVW) | (state_reg == PEI_PWR);

	// Byte returned for the current pointer
	always_comb begin
		if (ptr_reg == pei_pkg::ADDR_WIPER)
			rd_byte = volatile_only_select ? wiper_position_register
			                               : initial_wiper_value_store; // [R21]
		else if (ptr_reg == pei_pkg::ADDR_VOL_SEL)
			rd_byte = {volatile_only_select, 7'h00};
		else
			rd_byte = mem[ptr_reg];
	end

	// Input synchronisers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			wp_sync_reg  <= 2'h3;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], link.scl};
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
			wp_sync_reg  <= {wp_sync_reg[0], write_protect_n};
			scl_d_reg    <= scl_s;
			sda_d_reg    <= sda_s;
		end
	end

	// Protocol engine
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_reg      <= PEI_PWR;
			bit_cnt_reg    <= 4'h0;
			shift_reg      <= 8'h00;
			ptr_reg        <= 11'h000;
			sda_oe_reg     <= 1'b0;                                   // [R20]
			nv_pending_reg <= 1'b0;
			page_vld_reg   <= '0;
			page_base_reg  <= 11'h000;
			timer_reg      <= 32'h0;
			volatile_only_select      <= 1'b0;
			wiper_position_register   <= pei_pkg::WIPER_RESET;
			initial_wiper_value_store <= pei_pkg::INIT_WIPER_RST;
		end else if (state_reg == PEI_PWR) begin
			sda_oe_reg <= 1'b0;
			timer_reg  <= timer_reg + 32'h1;                          // [R3]
			if (timer_reg == 32'(pei_pkg::POWERUP_CYC)) begin
				wiper_position_register <= initial_wiper_value_store;
				state_reg <= PEI_IDLE;
			end
		end else if (state_reg == PEI_NVW) begin
			sda_oe_reg <= 1'b0;                                      // [R11]
			timer_reg  <= timer_reg + 32'h1;
			if (timer_reg == 32'(NV_CYC)) begin
				for (int i = 0; i < pei_pkg::PAGE_BYTES; i++) begin    // [R12]
					if (page_vld_reg[i])
						mem[{page_base_reg[10:4], 4'(i)}] <= page_buf[i];
				end
				page_vld_reg <= '0;
				state_reg    <= PEI_IDLE;                            // [R5]
			end
		end else if (start_c) begin
			state_reg   <= PEI_ID;                                   // [R3]
			// Clock fall that follows START wraps this to bit 0
			bit_cnt_reg <= 4'hf;
			sda_oe_reg  <= 1'b0;
		end else if (stop_c) begin
			sda_oe_reg <= 1'b0;
			timer_reg  <= 32'h0;
			if (nv_pending_reg) begin
				state_reg      <= PEI_NVW;                           // [R5]
				nv_pending_reg <= 1'b0;
			end else
				state_reg <= PEI_IDLE;                               // [R4]
		end else if (scl_rise && state_reg != PEI_IDLE && bit_cnt_reg == 4'h8) begin
			// Master acknowledge sampled during read
			if (state_reg == PEI_RACK && sda_s)
				state_reg <= PEI_IDLE;                               // [R8] [R18]
		end else if (scl_rise && state_reg != PEI_IDLE) begin
			shift_reg <= {shift_reg[6:0], sda_s};                    // [R1]
		end else if (scl_fall && state_reg != PEI_IDLE) begin
			unique case (state_reg)
				PEI_ID, PEI_ADDR, PEI_WDATA: begin
					if (bit_cnt_reg == 4'h7) begin
						bit_cnt_reg <= 4'h8;
						sda_oe_reg  <= 1'b1;                         // [R6] [R7]
						if (state_reg == PEI_ID) begin
							if (shift_reg[7:4] != pei_pkg::DEV_TYPE_CODE) begin
								sda_oe_reg <= 1'b0;                  // [R23]
								state_reg  <= PEI_IDLE;
							end else
								ptr_reg[10:8] <= shift_reg[3:1];     // [R9] [R10]
						end else if (state_reg == PEI_ADDR)
							ptr_reg[7:0] <= shift_reg;               // [R10]
						else if (!wp_sync_reg[1]) begin
							sda_oe_reg <= 1'b0;                      // [R15]
							state_reg  <= PEI_IDLE;
						end else begin
							ptr_reg <= {ptr_reg[10:4], ptr_reg[3:0] + 4'h1}; // [R13]
							if (ptr_reg == pei_pkg::ADDR_WIPER) begin
								wiper_position_register <= shift_reg;        // [R16]
								if (!volatile_only_select) begin             // [R22]
									initial_wiper_value_store <= shift_reg;
									nv_pending_reg <= 1'b1;
								end
							end else if (ptr_reg == pei_pkg::ADDR_VOL_SEL)
								volatile_only_select <= shift_reg[7];
							else begin
								page_buf[ptr_reg[3:0]] <= shift_reg;
								page_vld_reg[ptr_reg[3:0]] <= 1'b1;
								page_base_reg  <= ptr_reg;
								nv_pending_reg <= 1'b1;
							end
						end
					end else if (bit_cnt_reg == 4'h8) begin
						sda_oe_reg  <= 1'b0;
						bit_cnt_reg <= 4'h0;
						if (state_reg == PEI_ID && shift_reg[0]) begin   // [R17]
							state_reg   <= PEI_RDATA;
							shift_reg   <= rd_byte;
							sda_oe_reg  <= ~rd_byte[7];
							ptr_reg     <= ptr_reg + 11'h1;            // [R19]
						end else if (state_reg == PEI_ID)
							state_reg <= PEI_ADDR;
						else
							state_reg <= PEI_WDATA;
					end else
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
				PEI_RDATA, PEI_RACK: begin
					if (bit_cnt_reg == 4'h7) begin
						bit_cnt_reg <= 4'h8;
						sda_oe_reg  <= 1'b0;                         // [R6]
						state_reg   <= PEI_RACK;
					end else if (bit_cnt_reg == 4'h8) begin
						bit_cnt_reg <= 4'h0;
						state_reg   <= PEI_RDATA;
						shift_reg   <= rd_byte;
						sda_oe_reg  <= ~rd_byte[7];                  // [R1]
						ptr_reg     <= ptr_reg + 11'h1;              // [R19]
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						// Rise already shifted, so the next bit sits on top
						sda_oe_reg  <= ~shift_reg[7];                // [R1]
					end
				end
				default: state_reg <= PEI_IDLE;
			endcase
		end
	end
endmodule : pei_slave

// ===== hw/pei_master.sv
`timescale 1ns/1ps
// Bus master end: runs one command (write bytes or read bytes) per go pulse
module pei_master #(
	parameter int DIV = pei_pkg::LINK_DIV     // Clocks per link quarter step
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	pei_link_if.master      link,
	input  wire logic       go,               // Start command
	input  wire logic       rd,               // 1 = read, 0 = write
	input  wire logic [10:0] addr,            // Memory address
	input  wire logic [4:0] len,              // Data bytes, 1 to 16
	input  wire logic [7:0] wr_data,          // Next byte to write
	output logic            wr_take,          // Write byte consumed
	output logic [7:0]      rd_data,          // Received byte
	output logic            rd_valid,         // Received byte strobe
	output logic            nack,             // Slave did not acknowledge
	output logic            busy
);
	typedef enum logic [2:0] {
		PEM_IDLE = 3'b000, PEM_START = 3'b001, PEM_BIT = 3'b011, PEM_STOP = 3'b010
	} pem_state_t;

	pem_state_t  state_reg;
	logic [15:0] div_reg;       // Quarter-period divider
	logic [1:0]  ph_reg;        // Phase within bit
	logic [3:0]  bit_reg;       // Bit 0..8
	logic [2:0]  stage_reg;     // 0 id,1 addr,2 data,3 id-read,4 rdata
	logic [8:0]  sh_reg;        // Byte plus ack slot
	logic [4:0]  left_reg;      // Bytes remaining
	logic        scl_oe_reg, sda_oe_reg;
	logic [1:0]  sda_sync_reg;
	logic        tick;
	logic [7:0]  rx_reg;

	assign tick         = (div_reg == 16'(DIV - 1));
	assign link.scl_o   = 1'b0;
	assign link.scl_oe  = scl_oe_reg;
	assign link.sda_m_oe = sda_oe_reg;
	assign busy         = (state_reg != PEM_IDLE);

	// Divider and data synchroniser
	always_ff @(posedge clock) begin
		if (!nrst) begin
			div_reg      <= 16'h0;
			sda_sync_reg <= 2'h3;
		end else begin
			div_reg      <= tick ? 16'h0 : div_reg + 16'h1;
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
		end
	end

	// Bit sequencer: ph 0 low/set data, 1 rise, 2 sample, 3 fall
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_reg <= PEM_IDLE; ph_reg <= 2'h0; bit_reg <= 4'h0; stage_reg <= 3'h0;
			sh_reg <= 9'h000; left_reg <= 5'h0; scl_oe_reg <= 1'b0; sda_oe_reg <= 1'b0;
			wr_take <= 1'b0; rd_data <= 8'h00; rd_valid <= 1'b0; nack <= 1'b0; rx_reg <= 8'h00;
		end else begin
			wr_take  <= 1'b0;
			rd_valid <= 1'b0;
			if (state_reg == PEM_IDLE && go) begin
				state_reg <= PEM_START; ph_reg <= 2'h0; stage_reg <= 3'h0;
				left_reg <= len; nack <= 1'b0;
			end else if (tick && state_reg != PEM_IDLE) begin
				ph_reg <= ph_reg + 2'h1;
				unique case (state_reg)
					PEM_START: begin
						// Release both, then pull data low with clock high
						if (ph_reg == 2'h0) begin scl_oe_reg <= 1'b0; sda_oe_reg <= 1'b0; end
						else if (ph_reg == 2'h2) sda_oe_reg <= 1'b1;
						else if (ph_reg == 2'h3) begin
							scl_oe_reg <= 1'b1; state_reg <= PEM_BIT; bit_reg <= 4'h0;
							sh_reg <= (stage_reg == 3'h3) ? {pei_pkg::DEV_TYPE_CODE, addr[10:8], 1'b1, 1'b1}
							                              : {pei_pkg::DEV_TYPE_CODE, addr[10:8], 1'b0, 1'b1};
						end
					end
					PEM_BIT: begin
						if (ph_reg == 2'h0) sda_oe_reg <= ~sh_reg[8];
						else if (ph_reg == 2'h1) scl_oe_reg <= 1'b0;
						else if (ph_reg == 2'h2) begin
							if (bit_reg == 4'h8 && stage_reg != 3'h4 && sda_sync_reg[1]) nack <= 1'b1;
							if (bit_reg < 4'h8) rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
						end else begin
							scl_oe_reg <= 1'b1;
							sh_reg  <= {sh_reg[7:0], 1'b1};
							bit_reg <= bit_reg + 4'h1;
							if (bit_reg == 4'h7 && stage_reg == 3'h4) begin
								rd_data <= rx_reg; rd_valid <= 1'b1;
								left_reg <= left_reg - 5'h1;
								// Ack all but the last read byte
								sh_reg[8] <= (left_reg == 5'h1); // [R8]
							end
							if (bit_reg == 4'h8) begin
								bit_reg <= 4'h0;
								if (nack) state_reg <= PEM_STOP;
								else unique case (stage_reg)
									3'h0: begin stage_reg <= 3'h1; sh_reg <= {addr[7:0], 1'b1}; end
									3'h1: if (rd) begin stage_reg <= 3'h3; state_reg <= PEM_START; end // [R17]
									      else begin stage_reg <= 3'h2; sh_reg <= {wr_data, 1'b1}; wr_take <= 1'b1; end
									3'h2: if (left_reg == 5'h1) state_reg <= PEM_STOP;
									      else begin left_reg <= left_reg - 5'h1; sh_reg <= {wr_data, 1'b1}; wr_take <= 1'b1; end
									3'h3: begin stage_reg <= 3'h4; sh_reg <= 9'h1ff; end
									default: if (left_reg == 5'h0) state_reg <= PEM_STOP; else sh_reg <= 9'h1ff;
								endcase
							end
						end
					end
					default: begin
						// Stop: data low, clock high, then release data
						if (ph_reg == 2'h0) sda_oe_reg <= 1'b1;
						else if (ph_reg == 2'h1) scl_oe_reg <= 1'b0;
						else if (ph_reg == 2'h2) sda_oe_reg <= 1'b0;
						else state_reg <= PEM_IDLE;
					end
				endcase
			end
		end
	end
endmodule : pei_master

// ===== dv/pei_link_asserts.sv
`timescale 1ns/1ps
// Watches the shared two-wire link and the slave write-cycle flag
module pei_link_asserts (
	input wire logic clock,     // System clock
	input wire logic nrst,      // Synchronous reset, active low
	input wire logic scl_oe,    // Master pulls clock low
	input wire logic sda_m_oe,  // Master pulls data low
	input wire logic sda_s_oe,  // Slave pulls data low
	input wire logic scl,       // Resolved clock level
	input wire logic sda,       // Resolved data level
	input wire logic nv_busy    // Slave power-up or write cycle
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// Slave stays off the data line for eight cycles once reset lets go
	property p_rel; $rose(nrst) |-> !sda_s_oe [*8]; endproperty
	a_rel: assert property (p_rel) else $error("slave drives after reset");
	// Slave starts pulling only while the clock is low
	property p_drv_low; $rose(sda_s_oe) |-> !scl; endproperty
	a_drv_low: assert property (p_drv_low) else $error("slave drive in clock high");
	// Slave data is steady through a clock-high period
	property p_hold_hi; scl && $past(scl) |-> $stable(sda_s_oe); endproperty
	a_hold_hi: assert property (p_hold_hi) else $error("slave data moved in clock high");
	// A data fall in clock high is the master's START
	property p_start; scl && $past(scl) && $fell(sda) |-> sda_m_oe && scl_oe == 1'b0; endproperty
	a_start: assert property (p_start) else $error("data fall in clock high not master");
	// Slave has let go of the line by STOP
	property p_stop_free; scl && $past(scl) && $rose(sda) |-> !sda_s_oe; endproperty
	a_stop_free: assert property (p_stop_free) else $error("slave drives at stop");
	// Write cycle keeps the data output released
	property p_busy_quiet; nv_busy |-> !sda_s_oe; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("slave drives when busy");
	// Write cycle begins on an idle bus after STOP
	property p_busy_stop; $rose(nv_busy) |-> scl && sda; endproperty
	a_busy_stop: assert property (p_busy_stop) else $error("cycle not after stop");
	// Write cycle lasts a while
	property p_busy_min; $rose(nv_busy) |-> nv_busy [*8]; endproperty
	a_busy_min: assert property (p_busy_min) else $error("write cycle too short");
	// Write cycle ends in bounded time
	property p_busy_max; $rose(nv_busy) |-> ##[1:40] !nv_busy; endproperty
	a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
endmodule : pei_link_asserts

// ===== dv/tb_pot_eeprom_i2c_slave.sv
`timescale 1ns/1ps
// Joins master and slave ends; random pages plus wiper and protect cases
module tb_pot_eeprom_i2c_slave;
	localparam int NV = 20;        // Shortened write cycle
	logic        clock;            // System clock
	logic        nrst;             // Reset, active low
	logic        go;               // Command start
	logic        rd;               // Command direction
	logic [10:0] addr;             // Command address
	logic [4:0]  len;              // Command byte count
	logic [7:0]  wr_data;          // Byte offered to master
	logic        write_protect_n;  // Write protect, active low
	logic        wr_take;          // Master took a byte
	logic [7:0]  rd_data;          // Byte read by master
	logic        rd_valid;         // Read strobe
	logic        nack;             // Slave refused
	logic        busy;             // Master busy
	logic [7:0]  wiper;            // Wiper output
	logic        nv_busy;          // Slave busy
	logic [7:0]  wbuf [0:16];      // Bytes to write
	logic [7:0]  rbuf [0:16];      // Bytes read back
	logic [7:0]  mem [0:2047];     // Expected memory
	logic [7:0]  id_sh;            // Monitor shift register
	logic        scl_q;            // Previous clock level
	logic        sda_q;            // Previous data level
	logic [10:0] a;                // Scratch address
	logic [7:0]  v;                // Scratch value
	int          widx, ridx, id_n, n_start, error_cnt, n_checks;
	pei_link_if link ();
	pei_slave #(.NV_CYC(NV)) pei_slave_i (.clock(clock), .nrst(nrst), .link(link),
		.write_protect_n(write_protect_n), .wiper_position_register(wiper), .nv_busy(nv_busy));
	pei_master #(.DIV(4)) pei_master_i (.clock(clock), .nrst(nrst), .link(link), .go(go),
		.rd(rd), .addr(addr), .len(len), .wr_data(wr_data), .wr_take(wr_take),
		.rd_data(rd_data), .rd_valid(rd_valid), .nack(nack), .busy(busy));
	pei_link_asserts pei_link_asserts_i (.clock(clock), .nrst(nrst), .scl_oe(link.scl_oe),
		.sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda),
		.nv_busy(nv_busy));
	// Clock, 8 ns period
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Expected identification byte
	function automatic logic [7:0] id_exp(input logic [10:0] ad, input logic r);
		return {pei_pkg::DEV_TYPE_CODE, ad[10:8], r};
	endfunction : id_exp
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: byte %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	// Write bytes follow the master's take strobe; read bytes are collected
	always @(posedge clock) begin
		if (wr_take === 1'b1) widx <= widx + 1;
		if (rd_valid === 1'b1) begin
			rbuf[ridx] <= rd_data;
			ridx       <= ridx + 1;
		end
	end
	always @(negedge clock) wr_data = wbuf[widx];
	// Rebuilds each identification byte from the wires
	always @(posedge clock) begin
		scl_q <= link.scl;
		sda_q <= link.sda;
		if (link.scl && scl_q && sda_q && !link.sda) begin
			id_n    <= 0;
			n_start <= n_start + 1;
		end else if (link.scl && !scl_q && id_n < 8) begin
			id_sh <= {id_sh[6:0], link.sda};
			id_n  <= id_n + 1;
		end else if (id_n == 8) begin
			chk8(id_sh, id_exp(addr, rd && n_start == 2));
			id_n <= 9;
		end
	end
	// One command, bounded wait for the master to finish
	task automatic cmd(input logic r, input logic [10:0] ad, input logic [4:0] n);
		int k;
		@(negedge clock);
		{rd, addr, len, widx, ridx, n_start, go} = {r, ad, n, 32'h0, 32'h0, 32'h0, 1'b1};
		@(negedge clock);
		go = 1'b0;
		for (k = 0; busy !== 1'b0 && k < 8000; k++) @(negedge clock);
		if (k >= 8000) begin
			error_cnt++;
			$display("ERROR %0t: command hang", $time);
			end_of_test();
		end
	endtask : cmd
	task automatic wr(input logic [10:0] ad, input logic [4:0] n, input logic nv,
		input logic ref_nack);
		int k;
		cmd(1'b0, ad, n);
		chk1(nack, ref_nack);
		for (k = 0; nv_busy !== 1'b1 && k < 8; k++) @(negedge clock);
		chk1(nv_busy, nv);
		for (int i = 0; i < n; i++) if (!ref_nack) mem[{ad[10:4], ad[3:0] + i[3:0]}] = wbuf[i];
	endtask : wr
	task automatic wait_nv;
		int k;
		for (k = 0; nv_busy !== 1'b0 && k < 200; k++) @(negedge clock);
		chk1(nv_busy, 1'b0);
	endtask : wait_nv
	task automatic rdchk(input logic [10:0] ad, input logic [4:0] n);
		cmd(1'b1, ad, n);
		chk1(nack, 1'b0);
		chk8(ridx[7:0], {3'h0, n});
		for (int i = 0; i < n; i++) chk8(rbuf[i], mem[ad + i[10:0]]);
	endtask : rdchk
	// Writes the volatile-only bit from sel[7], then writes the wiper location
	task automatic wset(input logic [7:0] sel, input logic [7:0] val);
		wbuf[0] = sel;
		wr(pei_pkg::ADDR_VOL_SEL, 5'h1, 1'b0, 1'b0);
		wbuf[0] = val;
		wr(pei_pkg::ADDR_WIPER, 5'h1, ~sel[7], 1'b0);
		chk8(wiper, val);
	endtask : wset
	// Watchdog
	initial begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		$display("ERROR %0t: watchdog expired", $time);
		end_of_test();
	end
	// Main sequence
	initial begin
		{nrst, go, rd, addr, len, wr_data, write_protect_n} = {1'b0, 1'b0, 1'b0, 11'h0, 5'h1, 8'h0, 1'b1};
		{widx, ridx, id_n, n_start, error_cnt, n_checks} = {32'h0, 32'h0, 32'h9, 96'h0};
		void'($urandom(32'he7cf));
		repeat (12) @(negedge clock);
		nrst = 1'b1;
		@(negedge clock);
		chk1(link.sda_s_oe, 1'b0);
		chk1(nv_busy, 1'b1);
		cmd(1'b0, 11'h0, 5'h1);
		chk1(nack, 1'b1);
		wait_nv();
		$display("test powerup done");
		a = {7'($urandom_range(126, 0)), 4'h0};
		for (int i = 0; i < 16; i++) wbuf[i] = 8'($urandom());
		wr(a, 5'h10, 1'b1, 1'b0);
		cmd(1'b1, a, 5'h1);
		chk1(nack, 1'b1);
		wait_nv();
		rdchk(a, 5'h10);
		a = {7'($urandom_range(126, 0)), 4'hf};
		wbuf[0] = 8'($urandom());
		wr(a, 5'h1, 1'b1, 1'b0);
		wait_nv();
		rdchk(a, 5'h1);
		$display("test page done");
		write_protect_n = 1'b0;
		wbuf[0] = ~mem[a];
		wr(a, 5'h1, 1'b0, 1'b1);
		write_protect_n = 1'b1;
		rdchk(a, 5'h1);
		$display("test protect done");
		v = 8'($urandom());
		wset(8'h80, v);
		rdchk(pei_pkg::ADDR_WIPER, 5'h1);
		wset(8'h00, ~v);
		wait_nv();
		rdchk(pei_pkg::ADDR_WIPER, 5'h1);
		wset(8'h80, v ^ 8'h5a);
		wbuf[0] = 8'h00;
		wr(pei_pkg::ADDR_VOL_SEL, 5'h1, 1'b0, 1'b0);
		mem[pei_pkg::ADDR_WIPER] = ~v;
		rdchk(pei_pkg::ADDR_WIPER, 5'h1);
		$display("test wiper done");
		end_of_test();
	end
endmodule : tb_pot_eeprom_i2c_slave
